// ### dv/iau_integer_add_unit_asserts.sv
// Port checks for the integer add unit
`timescale 1ns/1ps
module iau_integer_add_unit_asserts (
    // Request
    input wire core_clk,
    input wire rst,
    input wire exec_en,
    input wire [1:0] op_code,
    input wire src1_is_const,
    input wire [31:0] src1_const,
    input wire src2_is_const,
    input wire [15:0] src2_const,
    // Answer
    input wire done_q,
    input wire [31:0] result_q,
    input wire zero_result_flag,
    input wire overflow_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire go = exec_en && op_code != 2'h3;
    wire kk = go && op_code == 2'h2 && src1_is_const && src2_is_const;
    property p_take; go |=> done_q; endproperty
    a_take: assert property (p_take) else $error("no done");
    property p_idle; !go |=> !done_q && !zero_result_flag && !overflow_flag; endproperty
    a_idle: assert property (p_idle) else $error("stray pulse");
    property p_zero; done_q |-> zero_result_flag == (result_q == 32'h0); endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_ovok; overflow_flag |-> done_q; endproperty
    a_ovok: assert property (p_ovok) else $error("lone overflow");
    property p_sext; go && op_code != 2'h1 |=> result_q[31:16] == {16{result_q[15]}}; endproperty
    a_sext: assert property (p_sext) else $error("sign");
    property p_ov16;
        kk |=> overflow_flag == ($past(src1_const[15]) == $past(src2_const[15])
            && result_q[15] != $past(src2_const[15]));
    endproperty
    a_ov16: assert property (p_ov16) else $error("overflow 16");
    property p_hold; !done_q |-> $stable(result_q); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_twin; done_q ##1 done_q |-> $past(go); endproperty
    a_twin: assert property (p_twin) else $error("done repeat");
    c_zero: cover property (zero_result_flag);
    c_ovf: cover property (overflow_flag);
    c_dw: cover property (go && op_code == 2'h1);
endmodule // iau_integer_add_unit_asserts
bind iau_integer_add_unit iau_integer_add_unit_asserts u_chk (.*);

// ### dv/iau_integer_add_unit_bench.sv
// Self-checking bench for the integer add unit
`timescale 1ns/1ps
module iau_integer_add_unit_bench;
    reg core_clk = 0;
    reg rst = 1;
    integer err_total = 0;
    integer checks_done = 0;
    integer cyc = 0;
    wire exec_en, src1_is_const, done_q, zero_result_flag, overflow_flag;
    wire src2_is_const;
    wire [3:0] src2_idx;
    wire [1:0] op_code;
    wire [3:0] src1_idx, dst_idx, rd_idx;
    wire [15:0] src2_const, rd_data_q;
    wire [31:0] src1_const, result_q;
    always #2.5 core_clk = ~core_clk;
    iau_seq_model u_seq (.*);
    iau_integer_add_unit u_dut (.*);
    task chk(input [34:0] got, input [34:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("FAIL %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Pulses and sum are judged on the answer cycle, before they drop
    task run(input [1:0] op, input c1, input [3:0] i1, input [31:0] k1, input [15:0] k2,
             input [3:0] d, input en, input [34:0] exp);
        begin
            u_seq.issue(op, c1, i1, k1, k2, d, en);
            chk({done_q, zero_result_flag, overflow_flag, result_q}, exp);
        end
    endtask
    task rd(input [3:0] i, input [15:0] exp);
        begin
            u_seq.rd_idx = i;
            @(negedge core_clk);
            chk(rd_data_q, exp);
        end
    endtask
    task t_16;
        begin
            run(2'h2, 1, 0, 32'h1b, 16'h0, 4'h2, 1, {3'h4, 32'h1b});
            run(2'h0, 1, 0, 32'h10, 16'h0, 4'h2, 0, {3'h0, 32'h1b});
            run(2'h0, 1, 0, 32'h10, 16'h0, 4'h2, 1, {3'h4, 32'h2b});
            rd(2, 16'h2b);
            $display("t_16 end");
        end
    endtask
    task t_32;
        begin
            run(2'h2, 1, 0, 32'hffff, 16'h0, 4'hf, 1, {3'h4, 32'hffffffff});
            run(2'h2, 1, 0, 32'h7fff, 16'h0, 4'h0, 1, {3'h4, 32'h7fff});
            run(2'h1, 1, 0, 32'h1, 16'h0, 4'hf, 1, {3'h5, 32'h80000000});
            rd(15, 16'h0);
            rd(0, 16'h8000);
            run(2'h1, 0, 4'hf, 32'h0, 16'h0, 4'hf, 1, {3'h7, 32'h0});
            $display("t_32 end");
        end
    endtask
    task t_3op;
        begin
            run(2'h2, 0, 4'h2, 32'h0, 16'hffd5, 4'h3, 1, {3'h6, 32'h0});
            rd(2, 16'h2b);
            run(2'h2, 1, 0, 32'h7fff, 16'h1, 4'h4, 1, {3'h5, 32'hffff8000});
            run(2'h2, 1, 0, 32'h8000, 16'hffff, 4'h4, 1, {3'h5, 32'h7fff});
            u_seq.src2_is_const = 1'b0;
            u_seq.src2_idx = 4'h2;
            run(2'h2, 0, 4'h2, 32'h0, 16'h0, 4'h5, 1, {3'h4, 32'h56});
            u_seq.src2_is_const = 1'b1;
            run(2'h3, 1, 0, 32'h5, 16'h0, 4'h5, 1, {3'h0, 32'h56});
            rd(5, 16'h56);
            $display("t_3op end");
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 400) begin
            err_total = err_total + 1;
            final_report;
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 0;
        t_16;
        t_32;
        t_3op;
        final_report;
    end
endmodule // iau_integer_add_unit_bench

// ### dv/iau_seq_model.sv
// Sequencer model issuing add requests
`timescale 1ns/1ps
module iau_seq_model (
    // Clock
    input wire core_clk,
    // Request
    output reg exec_en = 1'b0,
    output reg [1:0] op_code = 2'h3,
    output reg src1_is_const = 1'b0,
    output reg [3:0] src1_idx = 4'h0,
    output reg [31:0] src1_const = 32'h0,
    output reg src2_is_const = 1'b1,
    output reg [3:0] src2_idx = 4'h0,
    output reg [15:0] src2_const = 16'h0,
    output reg [3:0] dst_idx = 4'h0,
    output reg [3:0] rd_idx = 4'h0
);
    // Operands of one request are signed words, or signed double words for the 32-bit add
    task issue(input [1:0] op, input c1, input [3:0] i1, input [31:0] k1, input [15:0] k2,
               input [3:0] d, input en);
        begin
            @(negedge core_clk);
            {exec_en, op_code, src1_is_const, src1_idx} = {en, op, c1, i1};
            {src1_const, src2_const, dst_idx} = {k1, k2, d};
            @(negedge core_clk);
            exec_en = 1'b0;
        end
    endtask
endmodule // iau_seq_model

// ### hdl/iau_integer_add_unit.v
// Integer add unit: three signed add operations over a word area, with zero and overflow flags
`timescale 1ns/1ps
`include "iau_map.vh"

// Operation
// - In-place 16-bit add: source word or constant plus destination word.
// - Add only while enable trigger is high; otherwise nothing is computed.
// - In-place operations overwrite destination with the sum; augend is lost.
// - 16-bit operands and results are signed two's complement.
// - In-place 32-bit add: source double word or constant plus destination.
// - 32-bit operands and results are signed two's complement.
// - Three-operand 16-bit add writes sum of two sources to separate destination.
// - Zero result pulses the zero flag for one cycle.
// - 16-bit signed overflow or underflow pulses the overflow flag.
// - 32-bit signed overflow or underflow pulses the overflow flag.
module iau_integer_add_unit #(
    parameter AREA_WORDS = `IAU_AREA_WORDS,
    parameter IDX_W = `IAU_AREA_IDX_W
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Operation request from the sequencer
    input wire exec_en,
    input wire [1:0] op_code,
    input wire src1_is_const,
    input wire [IDX_W-1:0] src1_idx,
    input wire [31:0] src1_const,
    input wire src2_is_const,
    input wire [IDX_W-1:0] src2_idx,
    input wire [15:0] src2_const,
    input wire [IDX_W-1:0] dst_idx,
    // Word area read port
    input wire [IDX_W-1:0] rd_idx,
    output reg [15:0] rd_data_q,
    // Result and flags
    output reg done_q,
    output reg [31:0] result_q,
    output reg zero_result_flag,
    output reg overflow_flag
);

    // ------------------------------------------------------------
    // Word area
    // ------------------------------------------------------------
    reg [15:0] area_q [0:AREA_WORDS-1];
    reg [15:0] wr_lo_d;
    reg [15:0] wr_hi_d;
    reg wr_lo_en_d;
    reg wr_hi_en_d;
    reg [IDX_W-1:0] dst_hi_idx;

    // Double words occupy two consecutive words, low word first; the index wraps at the top
    function [IDX_W-1:0] next_idx;
        input [IDX_W-1:0] idx;
        begin
            next_idx = idx + {{(IDX_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // ------------------------------------------------------------
    // Operand selection and sums
    // ------------------------------------------------------------
    wire [15:0] s1_word = (src1_is_const == `IAU_SRC_CONST) ? src1_const[15:0] : area_q[src1_idx];
    wire [31:0] s1_dword = (src1_is_const == `IAU_SRC_CONST) ? src1_const :
                           {area_q[next_idx(src1_idx)], area_q[src1_idx]};
    wire [15:0] s2_word = (src2_is_const == `IAU_SRC_CONST) ? src2_const : area_q[src2_idx];
    wire [15:0] d_word = area_q[dst_idx];
    wire [31:0] d_dword = {area_q[next_idx(dst_idx)], area_q[dst_idx]};

    reg [15:0] a16;
    reg [15:0] b16;
    wire [15:0] sum16 = a16 + b16;
    wire [31:0] sum32 = s1_dword + d_dword;
    // Signed overflow: operands share a sign and the sum differs from it
    wire ovf16 = (a16[15] == b16[15]) && (sum16[15] != a16[15]);
    wire ovf32 = (s1_dword[31] == d_dword[31]) && (sum32[31] != d_dword[31]);

    reg [31:0] res_d;
    reg ovf_d;
    reg valid_d;

    always @* begin
        a16 = s1_word;
        b16 = d_word;
        res_d = 32'h0000_0000;
        ovf_d = 1'b0;
        valid_d = 1'b0;
        wr_lo_d = 16'h0000;
        wr_hi_d = 16'h0000;
        wr_lo_en_d = 1'b0;
        wr_hi_en_d = 1'b0;
        dst_hi_idx = next_idx(dst_idx);
        if (exec_en) begin
            case (op_code)
                `IAU_OP_ADD16_IN_PLACE: begin
                    a16 = s1_word;
                    b16 = d_word;
                    res_d = {{16{sum16[15]}}, sum16};
                    ovf_d = ovf16;
                    valid_d = 1'b1;
                    wr_lo_d = sum16;
                    wr_lo_en_d = 1'b1;
                end
                `IAU_OP_ADD32_IN_PLACE: begin
                    res_d = sum32;
                    ovf_d = ovf32;
                    valid_d = 1'b1;
                    wr_lo_d = sum32[15:0];
                    wr_hi_d = sum32[31:16];
                    wr_lo_en_d = 1'b1;
                    wr_hi_en_d = 1'b1;
                end
                `IAU_OP_ADD16_THREE_OPERAND: begin
                    a16 = s1_word;
                    b16 = s2_word;
                    res_d = {{16{sum16[15]}}, sum16};
                    ovf_d = ovf16;
                    valid_d = 1'b1;
                    wr_lo_d = sum16;
                    wr_lo_en_d = 1'b1;
                end
                default: begin
                    valid_d = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Storage update
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < AREA_WORDS; gi = gi + 1) begin : g_area
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    area_q[gi] <= `IAU_AREA_RESET;
                end else if (wr_lo_en_d && (dst_idx == gi)) begin
                    area_q[gi] <= wr_lo_d;
                end else if (wr_hi_en_d && (dst_hi_idx == gi)) begin
                    area_q[gi] <= wr_hi_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Result and flag pulses
    // ------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            result_q <= 32'h0000_0000;
            zero_result_flag <= 1'b0;
            overflow_flag <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            done_q <= valid_d;
            if (valid_d) begin
                result_q <= res_d;
            end
            // Flags last one cycle per executed add
            zero_result_flag <= valid_d && (res_d == 32'h0000_0000);
            overflow_flag <= valid_d && ovf_d;
            rd_data_q <= area_q[rd_idx];
        end
    end

endmodule // iau_integer_add_unit

// ### include/iau_map.vh
// Constants for the integer add unit: operation codes, widths, area reset value and operand source select
`ifndef IAU_MAP_VH
`define IAU_MAP_VH

// ------------------------------------------------------------
// Operation codes
// ------------------------------------------------------------
`define IAU_OP_ADD16_IN_PLACE 2'h0
`define IAU_OP_ADD32_IN_PLACE 2'h1
`define IAU_OP_ADD16_THREE_OPERAND 2'h2
`define IAU_OP_NONE 2'h3

// ------------------------------------------------------------
// Word storage
// ------------------------------------------------------------
`define IAU_WORD_W 16
`define IAU_DWORD_W 32
`define IAU_AREA_WORDS 16
`define IAU_AREA_IDX_W 4
`define IAU_AREA_RESET 16'h0000

// ------------------------------------------------------------
// Operand source select
// ------------------------------------------------------------
`define IAU_SRC_AREA 1'b0
`define IAU_SRC_CONST 1'b1

`endif
